/* bench/pulse_src.sv */
// Pulse source that drives the timer input pin.
// Assumes the same sys_clk as the timer.
`timescale 1ns/1ps
module pulse_src (
  input wire sys_clk,
  output logic timer_input_pin
);
  initial timer_input_pin = 1'b0;
  task lvl(input logic v, input int n);
    @(posedge sys_clk);
    timer_input_pin <= v;
    // Never under 16 cycles, so no edge outruns the input synchroniser
    repeat ((n < 16) ? 16 : n) @(posedge sys_clk);
  endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench of the capture timer over APB.
// Assumes LF_DIV of 2, so the slow low-frequency tick is 32 cycles.
`timescale 1ns/1ps
`include "timer_map.vh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata_r;
  wire pready_r, pslverr_r, timer_input_pin, timer_irq;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  logic [31:0] q, qb;
  logic [7:0] ctl [6] = '{8'h10, 8'h14, 8'h18, 8'h30, 8'h34, 8'h90};
  int per [6] = '{8192, 2048, 256, 64, 16, 64};
  timer_capture #(.LF_DIV(16'h0002)) DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .timer_input_pin(timer_input_pin), .timer_irq(timer_irq));
  pulse_src src (.sys_clk(sys_clk), .timer_input_pin(timer_input_pin));
  initial forever #2.5 sys_clk = ~sys_clk;
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready_r !== 1'b1);
    q = prdata_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(q, exp, nm);
  endtask
  // Waits out a falling irq first, so a stale level is not taken as new
  // A missing irq is left to the cycle ceiling, which counts it as a mismatch
  task wait_irq;
    repeat (2) @(posedge sys_clk);
    while (timer_irq !== 1'b1) begin
      @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`OFF_CTRL, 32'h0, "ctrl");
    rd(`OFF_IRQ_STATUS, 32'h0, "status");
    rd(8'h1C, 32'h0, "unmapped");
    apb(1'b1, `OFF_CTRL, 32'h40);
    rd(`OFF_CTRL, 32'h0, "software_capture_bit");
    rd(`OFF_REG_B, 32'h0, "b");
    rd(`OFF_COUNT, 32'h0, "stopped");
    apb(1'b1, `OFF_REG_A, 32'h2);
    apb(1'b1, `OFF_CTRL, 32'h11);
    src.lvl(1'b1, 16);
    rd(`OFF_COUNT, 32'h1, "ev count");
    src.lvl(1'b0, 16);
    src.lvl(1'b1, 16);
    rd(`OFF_COUNT, 32'h0, "ev wrap");
    check(timer_irq, 1'b0, "masked irq");
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(timer_irq, 1'b1, "irq");
    rd(`OFF_IRQ_STATUS, 32'h1, "status");
    repeat (2) @(posedge sys_clk);
    check(timer_irq, 1'b0, "irq clr");
    apb(1'b1, `OFF_EXT_CTRL, 32'h8);
    src.lvl(1'b0, 16);
    rd(`OFF_COUNT, 32'h1, "fall count");
    src.lvl(1'b1, 16);
    rd(`OFF_COUNT, 32'h1, "rise ignored");
    apb(1'b1, `OFF_EXT_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
      apb(1'b1, `OFF_CTRL, {24'h0, ctl[i]});
      wait_irq;
      t0 = cyc;
      apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
      wait_irq;
      check(cyc - t0, per[i], "period");
    end
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    src.lvl(1'b1, 16);
    apb(1'b1, `OFF_CTRL, 32'h92);
    src.lvl(1'b0, 100);
    src.lvl(1'b1, 100);
    apb(1'b0, `OFF_REG_B, 32'h0);
    qb = q;
    check(qb <= 1, 1'b1, "b fall");
    rd(`OFF_IRQ_STATUS, 32'h1, "cap flag");
    src.lvl(1'b0, 100);
    src.lvl(1'b1, 16);
    rd(`OFF_REG_B, qb, "b held");
    rd(`OFF_IRQ_STATUS, 32'h0, "no flag");
    apb(1'b0, `OFF_REG_A, 32'h0);
    check(q >= 3 && q <= 4, 1'b1, "a cap");
    src.lvl(1'b0, 50);
    src.lvl(1'b1, 16);
    apb(1'b0, `OFF_REG_B, 32'h0);
    qb = q;
    check(qb >= 6, 1'b1, "free run");
    apb(1'b0, `OFF_REG_A, 32'h0);
    check(q - qb >= 1 && q - qb <= 2, 1'b1, "a after b");
    src.lvl(1'b0, 16);
    rd(`OFF_IRQ_STATUS, 32'h1, "cap flag");
    apb(1'b0, `OFF_REG_B, 32'h0);
    check(q < 5, 1'b1, "cleared");
    // Overflow flags status bit 1, so it must be unmasked for the irq wait
    apb(1'b1, `OFF_IRQ_MASK, 32'h3);
    wait_irq;
    rd(`OFF_IRQ_STATUS, 32'h2, "ovf flag");
    rd(`OFF_REG_A, 32'hFF, "ovf a");
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h1C);
    repeat (300) @(posedge sys_clk);
    rd(`OFF_COUNT, 32'h0, "no tick");
    apb(1'b1, `OFF_CTRL, 32'h1B);
    repeat (300) @(posedge sys_clk);
    rd(`OFF_COUNT, 32'h0, "mode hold");
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0);
    apb(1'b1, `OFF_REG_A, 32'h5A);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`OFF_REG_A, 32'h5A, "a kept");
    final_report;
  end
endmodule

/* bench/timer_capture_chk.sv */
// Port checker of the capture timer.
// Assumes the timer_capture port list; bound below.
`timescale 1ns/1ps
`include "timer_map.vh"
module timer_capture_chk #(
  parameter [15:0] LF_DIV = `LF_DIV_DEFAULT
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_r,
  input wire pready_r,
  input wire pslverr_r,
  input wire timer_input_pin,
  input wire timer_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire setup = psel && !penable;
  a_ready_after_setup: assert property (setup |=> pready_r)
    else $error("ready missing");
  a_ready_one_cycle: assert property (pready_r |=> !pready_r)
    else $error("ready too long");
  a_ready_needs_setup: assert property (pready_r |-> $past(setup))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr_r |-> pready_r)
    else $error("error without ready");
  a_err_unmapped: assert property (setup && paddr > 8'h18 |=> pslverr_r)
    else $error("unmapped not refused");
  a_err_mapped_ok: assert property (setup && paddr <= 8'h18 && paddr[1:0] == 2'h0 |=> !pslverr_r)
    else $error("mapped refused");
  a_read_upper_zero: assert property (pready_r && !pwrite |-> prdata_r[31:8] == 24'h0)
    else $error("upper read bits set");
  a_write_reads_zero: assert property (pready_r && pwrite |-> prdata_r == 32'h0)
    else $error("write returned data");
  a_mask_off_quiet: assert property (pready_r && pwrite && paddr == `OFF_IRQ_MASK && pwdata[1:0] == 2'h0
    |=> ##1 !timer_irq [*3]) else $error("masked irq high");
endmodule
bind timer_capture timer_capture_chk #(.LF_DIV(LF_DIV)) chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
  .pready_r(pready_r), .pslverr_r(pslverr_r), .timer_input_pin(timer_input_pin), .timer_irq(timer_irq));

/* inc/timer_map.vh */
// Register map, field positions, reset values and divider figures of the 8-bit capture timer.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits of paddr.
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

`define OFF_CTRL 8'h00
`define OFF_EXT_CTRL 8'h04
`define OFF_REG_A 8'h08
`define OFF_REG_B 8'h0C
`define OFF_COUNT 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_MASK 8'h18

`define CTRL_MODE_LO 0
`define CTRL_SEL_LO 2
`define CTRL_RUN 4
`define CTRL_DIVSRC 5
`define CTRL_SOFTWARE_CAPTURE_BIT 6
`define CTRL_LOWSPD 7
`define EXT_EDGE_SEL 3

`define MODE_TIMER 2'h0
`define MODE_EVENT 2'h1
`define MODE_CAPTURE 2'h2

`define IRQ_MATCH 0
`define IRQ_OVF 1

`define CTRL_RESET 8'h00
`define EXT_RESET 1'h0
`define MASK_RESET 2'h0
`define STATUS_RESET 2'h0

`define HF_LOG2_SLOW 12
`define HF_LOG2_MID 10
`define HF_LOG2_FAST 7
`define LF_LOG2_SLOW 4
`define LF_LOG2_FAST 2
`define LF_DIV_DEFAULT 16'h17D7

`endif

/* rtl/pulse_div.v */
// Power-of-two divider of a one-cycle step pulse.
// Assumes step is a single-cycle enable on sys_clk.
`timescale 1ns/1ps
module pulse_div #(
  parameter LOG2 = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire step,
  output reg pulse_r
);
  reg [LOG2-1:0] cnt_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {LOG2{1'b0}};
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= step & (&cnt_r);
      if (step) begin
        cnt_r <= cnt_r + {{(LOG2-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* rtl/timer_capture.v */
// 8-bit timer, event counter and pulse capture unit with an APB register port.
// Assumes one 200 MHz sys_clk; the low-frequency oscillator is an enable derived from it.
`timescale 1ns/1ps
`include "timer_map.vh"
module timer_capture #(
  // sys_clk cycles per low_freq_osc period
  parameter [15:0] LF_DIV = `LF_DIV_DEFAULT
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  input wire timer_input_pin,
  output reg timer_irq
);
  reg [15:0] lf_cnt_r;
  reg lf_tick_r;
  wire hf_slow;
  wire hf_mid;
  wire hf_fast;
  wire lf_slow;
  wire lf_fast;
  reg [7:0] timer_control_reg;
  reg ext_edge_r;
  reg [7:0] compare_capture_reg_a;
  reg [7:0] capture_reg_b;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg armed_r;
  reg armed_nxt;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_s3_r;
  reg tick;
  reg a_load;
  reg [7:0] a_val;
  reg b_load;
  reg ev_match;
  reg ev_ovf;
  reg [31:0] rd_mux;
  reg addr_hit;
  wire [1:0] mode;
  wire [1:0] clk_sel;
  wire run;
  wire software_capture_bit;
  wire setup;
  wire access;
  wire wr_en;
  wire rd_en;
  wire rise;
  wire fall;
  wire act_edge;
  wire opp_edge;
  wire [7:0] cnt_inc;
  wire [1:0] status_nxt;

  assign mode = timer_control_reg[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
  assign clk_sel = timer_control_reg[`CTRL_SEL_LO+1:`CTRL_SEL_LO];
  assign run = timer_control_reg[`CTRL_RUN];
  assign software_capture_bit = timer_control_reg[`CTRL_SOFTWARE_CAPTURE_BIT];
  assign cnt_inc = cnt_r + 8'h01;

  // Low-frequency oscillator as an enable; LF_DIV is not a power of two, so it counts on its own
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lf_cnt_r <= 16'h0000;
      lf_tick_r <= 1'b0;
    end else if (lf_cnt_r == LF_DIV - 16'h0001) begin
      lf_cnt_r <= 16'h0000;
      lf_tick_r <= 1'b1;
    end else begin
      lf_cnt_r <= lf_cnt_r + 16'h0001;
      lf_tick_r <= 1'b0;
    end
  end

  pulse_div #(.LOG2(`HF_LOG2_SLOW)) div_hf_slow (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(1'b1),
    .pulse_r(hf_slow)
  );
  pulse_div #(.LOG2(`HF_LOG2_MID)) div_hf_mid (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(1'b1),
    .pulse_r(hf_mid)
  );
  pulse_div #(.LOG2(`HF_LOG2_FAST)) div_hf_fast (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(1'b1),
    .pulse_r(hf_fast)
  );
  pulse_div #(.LOG2(`LF_LOG2_SLOW)) div_lf_slow (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(lf_tick_r),
    .pulse_r(lf_slow)
  );
  pulse_div #(.LOG2(`LF_LOG2_FAST)) div_lf_fast (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(lf_tick_r),
    .pulse_r(lf_fast)
  );

  always @* begin
    tick = 1'b0;
    if (timer_control_reg[`CTRL_LOWSPD]) begin
      tick = lf_slow;
    end else begin
      case (clk_sel)
        2'h0: tick = timer_control_reg[`CTRL_DIVSRC] ? lf_slow : hf_slow;
        2'h1: tick = timer_control_reg[`CTRL_DIVSRC] ? lf_fast : hf_mid;
        2'h2: tick = hf_fast;
        default: tick = 1'b0;
      endcase
    end
  end

  // Pin synchroniser; edges are taken only from the second and third stages
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= timer_input_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_s3_r;
  assign fall = ~pin_s2_r & pin_s3_r;
  assign act_edge = ext_edge_r ? fall : rise;
  // Opposite edge is the other polarity
  assign opp_edge = ext_edge_r ? rise : fall;

  // APB: pready comes one cycle after setup, so every access has one wait-free access cycle
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_r;
  assign wr_en = access & pwrite & ~pslverr_r;
  assign rd_en = access & ~pwrite & ~pslverr_r;

  always @* begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      `OFF_CTRL: rd_mux = {24'h000000, timer_control_reg};
      `OFF_EXT_CTRL: rd_mux = {28'h0000000, ext_edge_r, 3'h0};
      `OFF_REG_A: rd_mux = {24'h000000, compare_capture_reg_a};
      `OFF_REG_B: rd_mux = {24'h000000, capture_reg_b};
      `OFF_COUNT: rd_mux = {24'h000000, cnt_r};
      `OFF_IRQ_STATUS: rd_mux = {30'h0, status_r};
      `OFF_IRQ_MASK: rd_mux = {30'h0, mask_r};
      default: addr_hit = 1'b0;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~addr_hit;
      if (setup) begin
        prdata_r <= (pwrite | ~addr_hit) ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Counter, capture and compare
  always @* begin
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    a_load = 1'b0;
    a_val = cnt_r;
    b_load = 1'b0;
    ev_match = 1'b0;
    ev_ovf = 1'b0;
    if (rd_en && paddr == `OFF_REG_A) begin
      armed_nxt = 1'b1;
    end
    if (!run) begin
      cnt_nxt = 8'h00;
      armed_nxt = 1'b1;
    end else begin
      case (mode)
        `MODE_TIMER: begin
          if (tick) begin
            if (cnt_inc == compare_capture_reg_a) begin
              cnt_nxt = 8'h00;
              ev_match = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        end
        `MODE_EVENT: begin
          if (act_edge) begin
            if (cnt_inc == compare_capture_reg_a) begin
              cnt_nxt = 8'h00;
              ev_match = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        end
        `MODE_CAPTURE: begin
          // Disarmed edges and overflows pass unseen, counter keeps running
          if (armed_r && act_edge) begin
            a_load = 1'b1;
            cnt_nxt = 8'h00;
            ev_match = 1'b1;
            armed_nxt = 1'b0;
          end else begin
            if (tick) begin
              cnt_nxt = cnt_inc;
            end
            if (armed_r && tick && cnt_r == 8'hFF) begin
              a_load = 1'b1;
              a_val = 8'hFF;
              ev_ovf = 1'b1;
              armed_nxt = 1'b0;
            end
            if (armed_r && opp_edge) begin
              b_load = 1'b1;
            end
          end
        end
        default: cnt_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      armed_r <= 1'b1;
      timer_control_reg <= `CTRL_RESET;
      ext_edge_r <= `EXT_RESET;
      mask_r <= `MASK_RESET;
    end else begin
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      if (wr_en && paddr == `OFF_CTRL) begin
        timer_control_reg <= pwdata[7:0];
      end else if (software_capture_bit) begin
        timer_control_reg[`CTRL_SOFTWARE_CAPTURE_BIT] <= 1'b0;
      end
      if (wr_en && paddr == `OFF_EXT_CTRL) begin
        ext_edge_r <= pwdata[`EXT_EDGE_SEL];
      end
      if (wr_en && paddr == `OFF_IRQ_MASK) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // No reset on the two timer registers
  always @(posedge sys_clk) begin
    if (a_load) begin
      compare_capture_reg_a <= a_val;
    end else if (wr_en && paddr == `OFF_REG_A) begin
      compare_capture_reg_a <= pwdata[7:0];
    end
    if (b_load || software_capture_bit) begin
      capture_reg_b <= cnt_r;
    end
  end

  // Read clears only the bits that were returned, so a flag set meanwhile survives
  assign status_nxt = (rd_en && paddr == `OFF_IRQ_STATUS) ? (status_r & ~prdata_r[1:0]) : status_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_r <= `STATUS_RESET;
      timer_irq <= 1'b0;
    end else begin
      status_r <= status_nxt | {ev_ovf, ev_match};
      timer_irq <= |(status_r & mask_r);
    end
  end
endmodule
